//--- core/bpt_core.sv
`timescale 1ns/1ps
module bpt_core
	import bpt_pkg::*;
#(
	parameter int DATA_W = BPT_DW
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// interrupt
	output logic irq_o,
	// a port data pins
	input wire logic [DATA_W-1:0] a_data_i,
	output logic [DATA_W-1:0] a_data_o,
	output logic a_data_oe_n_o,
	// a port parity pins
	input wire logic a_port_parity_bit_low_byte_i,
	output logic a_port_parity_bit_low_byte_o,
	output logic a_port_parity_bit_low_byte_oe_n_o,
	input wire logic a_port_parity_bit_high_byte_i,
	output logic a_port_parity_bit_high_byte_o,
	output logic a_port_parity_bit_high_byte_oe_n_o,
	// b port, parity in the two top bits
	input wire logic [DATA_W+1:0] b_port_i,
	output logic [DATA_W+1:0] b_port_o,
	output logic b_port_oe_n_o,
	// open-drain parity fault flags
	output logic parity_fault_flag_ab_o,
	output logic parity_fault_flag_ab_oe_n_o,
	output logic parity_fault_flag_ba_o,
	output logic parity_fault_flag_ba_oe_n_o
);

	////////////////////////////////////////////////////////////////////////
	// elaboration check: the packed state is built for the fixed width
	if (DATA_W != BPT_DW) begin : g_bad_width
		$error("bpt_core: DATA_W must equal the package width");
	end

	bpt_state_t cur, nxt;
	bpt_word_t ab_in, ab_stage, ab_out;
	bpt_word_t ba_in, ba_stage;
	logic [BPT_BYTES-1:0] gen_par_ab, err_ab_byte, err_ba_byte;
	logic err_ab, err_ba, gen_mode;
	logic [BPT_EV_W-1:0] live_err;
	logic setup, access;

	////////////////////////////////////////////////////////////////////////
	// input capture and pin sensing
	assign gen_mode = ~cur.ctrl.check_sel;
	// a parity sensing is disabled in generate mode so a floating pin is
	// harmless while nothing drives it
	always_comb begin
		ab_in.data = a_data_i;
		ab_in.par[0] = gen_mode ? 1'b0 : a_port_parity_bit_low_byte_i;
		ab_in.par[1] = gen_mode ? 1'b0 : a_port_parity_bit_high_byte_i;
		ba_in = b_port_i;
	end

	// staging: buffer passes, latch is transparent while enabled,
	// register shows the word taken at the last edge
	always_comb begin
		case (cur.ctrl.mode_ab)
			BPT_MODE_LATCH: ab_stage = cur.ctrl.le_ab ? ab_in : cur.hold_ab;
			BPT_MODE_REG: ab_stage = cur.hold_ab;
			default: ab_stage = ab_in;
		endcase
		case (cur.ctrl.mode_ba)
			BPT_MODE_LATCH: ba_stage = cur.ctrl.le_ba ? ba_in : cur.hold_ba;
			BPT_MODE_REG: ba_stage = cur.hold_ba;
			default: ba_stage = ba_in;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// per-byte parity trees on the staged words
	for (genvar i = 0; i < BPT_BYTES; i++) begin : g_byte
		logic [BPT_BYTE_W-1:0] ab_byte, ba_byte;
		assign ab_byte = ab_stage.data[i*BPT_BYTE_W +: BPT_BYTE_W];
		assign ba_byte = ba_stage.data[i*BPT_BYTE_W +: BPT_BYTE_W];
		// odd sense makes the total count of ones odd
		assign gen_par_ab[i] = (^ab_byte) ^ cur.ctrl.odd_sense;
		assign err_ab_byte[i] =
			((^ab_byte) ^ ab_stage.par[i]) != cur.ctrl.odd_sense;
		assign err_ba_byte[i] =
			((^ba_byte) ^ ba_stage.par[i]) != cur.ctrl.odd_sense;
	end

	// errors are judged on the staged word, so they line up with its data
	assign err_ab = cur.ctrl.en_ab & ~gen_mode & (|err_ab_byte);
	assign err_ba = cur.ctrl.en_ba & (|err_ba_byte);
	assign live_err = {err_ba, err_ab};

	////////////////////////////////////////////////////////////////////////
	// port drive
	always_comb begin
		ab_out.data = ab_stage.data;
		ab_out.par = gen_mode ? gen_par_ab : ab_stage.par;
	end
	assign b_port_o = ab_out;
	assign b_port_oe_n_o = ~cur.ctrl.en_ab;
	assign a_data_o = ba_stage.data;
	assign a_data_oe_n_o = ~cur.ctrl.en_ba;
	assign a_port_parity_bit_low_byte_o = ba_stage.par[0];
	assign a_port_parity_bit_high_byte_o = ba_stage.par[1];
	assign a_port_parity_bit_low_byte_oe_n_o = ~cur.ctrl.en_ba;
	assign a_port_parity_bit_high_byte_oe_n_o = ~cur.ctrl.en_ba;

	// open drain: the level is always low, only the enable moves, so
	// several flags may share one pulled-up wire
	assign parity_fault_flag_ab_o = 1'b0;
	assign parity_fault_flag_ab_oe_n_o = ~err_ab;
	assign parity_fault_flag_ba_o = 1'b0;
	assign parity_fault_flag_ba_oe_n_o = ~err_ba;

	////////////////////////////////////////////////////////////////////////
	// apb: zero wait states, read data fetched in the setup cycle
	assign setup = psel_i & ~penable_i;
	assign access = psel_i & penable_i;
	assign pready_o = 1'b1;
	assign prdata_o = cur.prdata;
	assign pslverr_o = cur.pslverr;
	assign irq_o = |(cur.stat & cur.mask);

	// next state: holds, registers, read fetch
	always_comb begin
		logic [BPT_EV_W-1:0] clr;
		clr = '0;
		nxt = cur;
		// holds load on every edge in register mode, only while
		// open in latch mode
		if (cur.ctrl.mode_ab == BPT_MODE_REG ||
			(cur.ctrl.mode_ab == BPT_MODE_LATCH && cur.ctrl.le_ab)) begin
			nxt.hold_ab = ab_in;
		end
		if (cur.ctrl.mode_ba == BPT_MODE_REG ||
			(cur.ctrl.mode_ba == BPT_MODE_LATCH && cur.ctrl.le_ba)) begin
			nxt.hold_ba = ba_in;
		end
		if (setup) begin
			nxt.pslverr = 1'b0;
			nxt.prdata = '0;
			case (paddr_i)
				BPT_CTRL_ADDR: nxt.prdata[BPT_CTRL_W-1:0] = cur.ctrl;
				BPT_STAT_ADDR: nxt.prdata[BPT_EV_W-1:0] = cur.stat;
				BPT_MASK_ADDR: nxt.prdata[BPT_EV_W-1:0] = cur.mask;
				BPT_LIVE_ADDR: nxt.prdata[BPT_EV_W-1:0] = live_err;
				default: nxt.pslverr = 1'b1;
			endcase
		end
		if (access && pwrite_i) begin
			case (paddr_i)
				BPT_CTRL_ADDR: nxt.ctrl = bpt_ctrl_t'(pwdata_i[BPT_CTRL_W-1:0]);
				BPT_STAT_ADDR: clr = pwdata_i[BPT_EV_W-1:0];
				BPT_MASK_ADDR: nxt.mask = pwdata_i[BPT_EV_W-1:0];
				default: ;
			endcase
		end
		// a new error wins over a same-cycle write-one clear
		nxt.stat = (cur.stat & ~clr) | live_err;
	end

	// state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur <= '0;
			cur.ctrl <= BPT_CTRL_RST;
		end else begin
			cur <= nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_sense_flip;
		$changed(cur.ctrl.odd_sense) && $stable(ab_stage.data);
	endsequence

	a_gen_sense_flip: assert property (
		s_sense_flip and (gen_mode && $past(gen_mode)) |->
		b_port_o[DATA_W+1:DATA_W] == ~$past(b_port_o[DATA_W+1:DATA_W]))
		else $error("generated parity did not invert on sense change");

	a_chk_sense_flip: assert property (
		$changed(cur.ctrl.odd_sense) && $stable(ba_stage) &&
		cur.ctrl.en_ba && $past(cur.ctrl.en_ba) && !$past(err_ba_byte[0]) |->
		!parity_fault_flag_ba_oe_n_o)
		else $error("sense flip in check mode raised no error");

	a_dir_isolate: assert property (
		!cur.ctrl.en_ab |-> parity_fault_flag_ab_oe_n_o)
		else $error("a-to-b flag pulled low while direction idle");

	a_par_forward: assert property (
		cur.ctrl.check_sel |-> b_port_o[DATA_W+1:DATA_W] == ab_stage.par)
		else $error("received parity not forwarded a to b");

	a_data_pass: assert property (
		cur.ctrl.mode_ba == BPT_MODE_BUF |-> a_data_o == b_port_i[DATA_W-1:0])
		else $error("buffer mode altered b-to-a data");

	a_reg_delay: assert property (
		cur.ctrl.mode_ab == BPT_MODE_REG && $past(cur.ctrl.mode_ab) ==
		BPT_MODE_REG |-> b_port_o[DATA_W-1:0] == $past(a_data_i))
		else $error("register mode did not delay data one cycle");

	a_flag_release: assert property (
		!err_ab |-> parity_fault_flag_ab_oe_n_o && !parity_fault_flag_ab_o)
		else $error("fault flag driven without an error");

	a_byte_check: assert property (
		cur.ctrl.en_ba && ((^ba_stage.data[15:8]) ^ ba_stage.par[1]) !=
		cur.ctrl.odd_sense |-> !parity_fault_flag_ba_oe_n_o)
		else $error("high byte parity error not flagged");

	a_gen_ignore_in: assert property (
		gen_mode |-> ab_in.par == '0 && !parity_fault_flag_ab_oe_n_o == 1'b0)
		else $error("a parity inputs sensed in generate mode");

	a_sticky_set: assert property (
		err_ba |=> cur.stat[BPT_EV_BA] [*1])
		else $error("error did not reach status the next cycle");

endmodule : bpt_core

//--- shared/bpt_pkg.sv
package bpt_pkg;
	// datapath geometry
	localparam int BPT_DW = 16;
	localparam int BPT_BYTES = 2;
	localparam int BPT_BYTE_W = 8;
	// register byte addresses
	localparam logic [7:0] BPT_CTRL_ADDR = 8'h00;
	localparam logic [7:0] BPT_STAT_ADDR = 8'h04;
	localparam logic [7:0] BPT_MASK_ADDR = 8'h08;
	localparam logic [7:0] BPT_LIVE_ADDR = 8'h0C;
	// per-direction staging modes
	localparam logic [1:0] BPT_MODE_BUF = 2'h0;
	localparam logic [1:0] BPT_MODE_LATCH = 2'h1;
	localparam logic [1:0] BPT_MODE_REG = 2'h2;
	// status and mask bit positions
	localparam int BPT_EV_AB = 0;
	localparam int BPT_EV_BA = 1;
	localparam int BPT_EV_W = 2;
	// control register, low bits of the word
	typedef struct packed {
		logic en_ba;
		logic en_ab;
		logic le_ba;
		logic le_ab;
		logic [1:0] mode_ba;
		logic [1:0] mode_ab;
		logic odd_sense;
		logic check_sel;
	} bpt_ctrl_t;
	localparam int BPT_CTRL_W = 10;
	localparam bpt_ctrl_t BPT_CTRL_RST = '{default: 1'b0, check_sel: 1'b1};
	// one direction: data plus one parity bit per byte
	typedef struct packed {
		logic [BPT_BYTES-1:0] par;
		logic [BPT_DW-1:0] data;
	} bpt_word_t;
	// whole module state
	typedef struct packed {
		bpt_ctrl_t ctrl;
		logic [BPT_EV_W-1:0] stat;
		logic [BPT_EV_W-1:0] mask;
		bpt_word_t hold_ab;
		bpt_word_t hold_ba;
		logic [31:0] prdata;
		logic pslverr;
	} bpt_state_t;
endpackage : bpt_pkg

//--- testbench/bpt_agents.sv
`timescale 1ns/1ps
// bus agents on both ports; device drive wins over agent drive
module bpt_agents
	import bpt_pkg::*;
(
	// agent words
	input wire bpt_word_t a_drv_i,
	input wire bpt_word_t b_drv_i,
	// device side
	input wire bpt_word_t a_dev_i,
	input wire logic a_oe_n_i,
	input wire bpt_word_t b_dev_i,
	input wire logic b_oe_n_i,
	input wire logic [1:0] flag_oe_n_i,
	// resolved wires
	output bpt_word_t a_wire_o,
	output bpt_word_t b_wire_o,
	output logic [1:0] flag_n_o
);
	////////////////////////////////////////////////////////////////
	// agents back off whenever the device owns the port
	assign a_wire_o = !a_oe_n_i ? a_dev_i : a_drv_i;
	assign b_wire_o = !b_oe_n_i ? b_dev_i : b_drv_i;
	// pull-up on the shared lines, so a release reads high
	assign flag_n_o = flag_oe_n_i;
endmodule : bpt_agents

//--- testbench/bpt_core_test.sv
`timescale 1ns/1ps
module bpt_core_test
	import bpt_pkg::*;
;
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, a_oe_n, b_oe_n, plo, phi, slv;
	logic [1:0] foe, flag_n;
	logic [17:0] b_o;
	logic [15:0] a_o;
	bpt_word_t a_drv = '0, b_drv = '0, a_w, b_w, w1, w2;
	bpt_ctrl_t c;
	int err_count = 0, samples_checked = 0, cyc = 0;
	////////////////////////////////////////////////////////////////
	bpt_core u_bpt_core (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .irq_o(irq), .a_data_i(a_w.data),
		.a_data_o(a_o), .a_data_oe_n_o(a_oe_n),
		.a_port_parity_bit_low_byte_i(a_w.par[0]),
		.a_port_parity_bit_low_byte_o(plo),
		.a_port_parity_bit_low_byte_oe_n_o(),
		.a_port_parity_bit_high_byte_i(a_w.par[1]),
		.a_port_parity_bit_high_byte_o(phi),
		.a_port_parity_bit_high_byte_oe_n_o(), .b_port_i(b_w),
		.b_port_o(b_o), .b_port_oe_n_o(b_oe_n),
		.parity_fault_flag_ab_o(), .parity_fault_flag_ab_oe_n_o(foe[0]),
		.parity_fault_flag_ba_o(), .parity_fault_flag_ba_oe_n_o(foe[1]));
	bpt_agents u_bpt_agents (.a_drv_i(a_drv), .b_drv_i(b_drv),
		.a_dev_i({phi, plo, a_o}), .a_oe_n_i(a_oe_n), .b_dev_i(b_o),
		.b_oe_n_i(b_oe_n), .flag_oe_n_i(foe), .a_wire_o(a_w),
		.b_wire_o(b_w), .flag_n_o(flag_n));
	////////////////////////////////////////////////////////////////
	// clock and a hang guard well beyond the 56 or so cycles used
	initial forever #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	task print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	// one apb transfer; waits on pready, no fixed latency assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'h1;
		do @(posedge clk_i); while (pready !== 1'h1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask : apb
	task put(input bpt_word_t a, input bpt_word_t b);
		@(posedge clk_i);
		a_drv <= a;
		b_drv <= b;
		#1;
	endtask : put
	// word with correct parity for the given sense
	function automatic bpt_word_t wd(logic [15:0] d, logic odd);
		return {^d[15:8] ^ odd, ^d[7:0] ^ odd, d};
	endfunction : wd
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'h1;
		w1 = wd(16'h0301, 1'h0);
		w2 = wd(16'hA5F0, 1'h0) ^ 18'h20000;
		apb(1'h0, BPT_CTRL_ADDR, 32'h0);
		chk(rd, 32'h001);
		apb(1'h0, 8'h10, 32'h0);
		chk({rd[30:0], slv}, 32'h1);
		$display("regs done");
		// check mode, buffer a to b, then sense flipped
		c = BPT_CTRL_RST;
		c.en_ab = 1'h1;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		put(w1, w1);
		chk(b_o, w1);
		chk(flag_n, 2'h3);
		c.odd_sense = 1'h1;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		chk(flag_n, 2'h2);
		apb(1'h0, BPT_STAT_ADDR, 32'h0);
		chk({rd[30:0], irq}, 32'h2);
		apb(1'h1, BPT_MASK_ADDR, 32'h1);
		chk(irq, 32'h1);
		put(wd(16'h0301, 1'h1) ^ 18'h10000, w1);
		chk(flag_n, 2'h2);
		put(wd(16'h0301, 1'h1), w1);
		apb(1'h1, BPT_STAT_ADDR, 32'h1);
		chk({flag_n, irq}, 32'h6);
		$display("check done");
		// generate mode: parity from data, sense inverts it at once
		c.check_sel = 1'h0;
		c.odd_sense = 1'h0;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		put({2'h0, 16'h0301}, w1);
		chk({flag_n, b_o}, {2'h3, w1});
		c.odd_sense = 1'h1;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		chk(b_o, wd(16'h0301, 1'h1));
		$display("generate done");
		// register then latch staging, flags follow staged word
		c = BPT_CTRL_RST;
		c.en_ab = 1'h1;
		c.mode_ab = BPT_MODE_REG;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		put(w1, w1);
		put(w2, w1);
		chk({flag_n, b_o}, {2'h3, w1});
		@(posedge clk_i);
		#1;
		chk({flag_n, b_o}, {2'h2, w2});
		c.mode_ab = BPT_MODE_LATCH;
		c.le_ab = 1'h1;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		put(w1, w1);
		chk(b_o, w1);
		c.le_ab = 1'h0;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		put(w2, w1);
		chk(b_o, w1);
		$display("staging done");
		// b to a forwards parity and flags its own direction only
		c = BPT_CTRL_RST;
		c.en_ba = 1'h1;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		put(w1, w2);
		chk({phi, plo, a_o}, w2);
		chk(flag_n, 2'h1);
		// sense flip in check mode moves the fault to the other byte
		c.odd_sense = 1'h1;
		apb(1'h1, BPT_CTRL_ADDR, {22'h0, c});
		chk(flag_n, 2'h1);
		$display("reverse done");
		print_verdict();
	end
endmodule : bpt_core_test
